//--- core/acc_defines.svh
// Register map, field positions and reset values of the comparator control block
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

`define ACC_ADDR_W       8
`define ACC_DATA_W       8
`define ACC_ADDR_CTRL    8'h18
`define ACC_ADDR_SEL     8'h19
`define ACC_ADDR_STAT    8'h3A
`define ACC_ADDR_MASK    8'h3B
`define ACC_CTRL_RESET   8'h00
`define ACC_SEL_RESET    8'h00
`define ACC_STAT_RESET   2'h0
`define ACC_MASK_RESET   2'h0
`define ACC_READ_IDLE    8'h00
`define ACC_CTRL_RES_BIT 6
`define ACC_STAT_W       2
`define ACC_STAT_CHG     0
`define ACC_STAT_WAKE    1

`endif

//--- core/acc_pkg.sv
// Types shared by the comparator control block
package acc_pkg;

   // Comparator control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       enable;
      logic       result;
      logic       sample;
      logic       invert;
      logic [2:0] minus_sel;
      logic       plus_sel;
   } acc_ctrl_s;

   // Comparator selection register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       out_en;
      logic       wake_en;
      logic       range_high;
      logic       range_low;
      logic [3:0] level;
   } acc_sel_s;

endpackage

//--- core/acc_sync.sv
// Two-flop synchroniser for the asynchronous comparator result
`timescale 1ns/1ps
`default_nettype none

module acc_sync (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic async_i,
   output logic      sync_o
);

   logic stage1;
   logic stage2;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;

endmodule

`default_nettype wire

//--- core/acc_top.sv
// Comparator control block: registers, result path, wake-up and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"

module acc_top
   import acc_pkg::*;
(
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic [`ACC_ADDR_W-1:0]   reg_addr_i,
   input  wire logic [`ACC_DATA_W-1:0]   reg_wdata_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   output logic      [`ACC_DATA_W-1:0]   reg_rdata_o,
   input  wire logic                     cmp_raw_i,
   input  wire logic                     timer2_clock_i,
   output logic                          cmp_enable_o,
   output logic      [2:0]               minus_sel_o,
   output logic                          plus_sel_o,
   output logic                          range_high_o,
   output logic                          range_low_o,
   output logic      [3:0]               level_o,
   output logic                          port_a_pin_zero_o,
   output logic                          port_a_pin_zero_oe_o,
   output logic                          timer2_cmp_clk_o,
   output logic                          wakeup_o,
   output logic                          irq_o
);

   // Address match used by both the write and read decoders
   function automatic logic addr_is(input logic [`ACC_ADDR_W-1:0] a,
                                    input logic [`ACC_ADDR_W-1:0] target);
      addr_is = (a == target);
   endfunction

   acc_ctrl_s                 ctrl;
   acc_ctrl_s                 next_ctrl;
   acc_sel_s                  sel;
   acc_sel_s                  next_sel;
   logic [`ACC_STAT_W-1:0]    stat;
   logic [`ACC_STAT_W-1:0]    next_stat;
   logic [`ACC_STAT_W-1:0]    mask;
   logic [`ACC_STAT_W-1:0]    next_mask;
   logic [`ACC_DATA_W-1:0]    rdata;
   logic [`ACC_DATA_W-1:0]    next_rdata;
   logic                      irq;
   logic                      next_irq;
   logic                      cmp_sync;
   logic                      res_now;
   logic                      res_q;
   logic                      t2_q;
   logic                      t2_rise;
   logic                      sampled_q;
   logic                      next_sampled;
   logic                      path;
   logic                      pin;
   logic                      next_pin;
   logic                      t2out;
   logic                      next_t2out;
   logic                      wake;
   logic                      next_wake;
   logic                      chg_evt;
   logic                      wake_evt;

   // Raw comparator result enters the clock domain here
   acc_sync u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .async_i    (cmp_raw_i),
      .sync_o     (cmp_sync)
   );

   // Result path: gating, timer2 sampling, polarity and change detection
   always_comb begin
      res_now      = ctrl.enable & cmp_sync;
      t2_rise      = timer2_clock_i & ~t2_q;
      next_sampled = t2_rise ? res_now : sampled_q;
      path         = (ctrl.sample ? sampled_q : res_now)
                     ^ ctrl.invert;
      next_pin     = path;
      next_t2out   = path;
      chg_evt      = (res_now != res_q);
      wake_evt     = sel.wake_en & chg_evt;
      next_wake    = wake_evt;
   end

   // Result path registers
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         res_q     <= 1'b0;
         t2_q      <= 1'b0;
         sampled_q <= 1'b0;
         pin       <= 1'b0;
         t2out     <= 1'b0;
         wake      <= 1'b0;
      end else begin
         res_q     <= res_now;
         t2_q      <= timer2_clock_i;
         sampled_q <= next_sampled;
         pin       <= next_pin;
         t2out     <= next_t2out;
         wake      <= next_wake;
      end
   end

   // Register writes, sticky status with set over clear, read data
   always_comb begin
      next_ctrl  = ctrl;
      next_sel   = sel;
      next_mask  = mask;
      next_stat  = stat;
      next_rdata = `ACC_READ_IDLE;
      if (reg_wr_i && addr_is(reg_addr_i, `ACC_ADDR_CTRL)) begin
         next_ctrl        = acc_ctrl_s'(reg_wdata_i);
         next_ctrl.result = 1'b0;                            // Read-only bit is not stored
      end
      if (reg_wr_i && addr_is(reg_addr_i, `ACC_ADDR_SEL)) begin
         next_sel = acc_sel_s'(reg_wdata_i);
      end
      if (reg_wr_i && addr_is(reg_addr_i, `ACC_ADDR_MASK)) begin
         next_mask = reg_wdata_i[`ACC_STAT_W-1:0];
      end
      if (reg_wr_i && addr_is(reg_addr_i, `ACC_ADDR_STAT)) begin
         next_stat = stat & ~reg_wdata_i[`ACC_STAT_W-1:0];
      end
      next_stat[`ACC_STAT_CHG]  = next_stat[`ACC_STAT_CHG] | chg_evt;
      next_stat[`ACC_STAT_WAKE] = next_stat[`ACC_STAT_WAKE] | wake_evt;
      next_irq = |(next_stat & next_mask);
      if (reg_rd_i) begin
         if (addr_is(reg_addr_i, `ACC_ADDR_CTRL)) begin
            next_rdata                   = ctrl;
            next_rdata[`ACC_CTRL_RES_BIT] = res_now;
         end else if (addr_is(reg_addr_i, `ACC_ADDR_STAT)) begin
            next_rdata[`ACC_STAT_W-1:0] = stat;
         end else if (addr_is(reg_addr_i, `ACC_ADDR_MASK)) begin
            next_rdata[`ACC_STAT_W-1:0] = mask;
         end
      end
   end

   // Register file flops
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl  <= acc_ctrl_s'(`ACC_CTRL_RESET);
         sel   <= acc_sel_s'(`ACC_SEL_RESET);
         stat  <= `ACC_STAT_RESET;
         mask  <= `ACC_MASK_RESET;
         rdata <= `ACC_READ_IDLE;
         irq   <= 1'b0;
      end else begin
         ctrl  <= next_ctrl;
         sel   <= next_sel;
         stat  <= next_stat;
         mask  <= next_mask;
         rdata <= next_rdata;
         irq   <= next_irq;
      end
   end

   // Outputs straight from flops
   assign reg_rdata_o          = rdata;
   assign cmp_enable_o         = ctrl.enable;
   assign minus_sel_o          = ctrl.minus_sel;
   assign plus_sel_o           = ctrl.plus_sel;
   assign range_high_o         = sel.range_high;
   assign range_low_o          = sel.range_low;
   assign level_o              = sel.level;
   assign port_a_pin_zero_o    = pin;
   assign port_a_pin_zero_oe_o = sel.out_en;
   assign timer2_cmp_clk_o     = t2out;
   assign wakeup_o             = wake;
   assign irq_o                = irq;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_ctrl_write;
      reg_wr_i && addr_is(reg_addr_i, `ACC_ADDR_CTRL);
   endsequence

   sequence s_sel_write;
      reg_wr_i && addr_is(reg_addr_i, `ACC_ADDR_SEL);
   endsequence

   sequence s_raw_steady;
      ($stable(cmp_raw_i) && ctrl.enable && !reg_wr_i) [*3];
   endsequence

   a_enable_follow: assert property (s_ctrl_write |=> cmp_enable_o == $past(reg_wdata_i[7]))
      else $error("comparator enable does not follow control write");
   a_result_read: assert property (
      reg_rd_i && addr_is(reg_addr_i, `ACC_ADDR_CTRL) |=> reg_rdata_o[6] == $past(res_now))
      else $error("result bit read back wrong");
   a_sample_hold: assert property (ctrl.sample && !t2_rise |=> $stable(sampled_q))
      else $error("sampled result changed without timer2 edge");
   a_invert_path: assert property (
      !ctrl.sample |=> port_a_pin_zero_o == ($past(res_now) ^ $past(ctrl.invert)))
      else $error("output polarity wrong");
   a_minus_select: assert property (s_ctrl_write |=> minus_sel_o == $past(reg_wdata_i[3:1]))
      else $error("minus input select wrong");
   a_plus_select: assert property (s_ctrl_write |=> plus_sel_o == $past(reg_wdata_i[0]))
      else $error("plus input select wrong");
   a_pin_enable: assert property (s_sel_write |=> port_a_pin_zero_oe_o == $past(reg_wdata_i[7]))
      else $error("pin output enable wrong");
   a_wake_change: assert property (sel.wake_en && chg_evt |=> wakeup_o ##1 1'b1)
      else $error("missing wake-up on result change");
   a_wake_off: assert property (!sel.wake_en |=> !wakeup_o)
      else $error("wake-up while disabled");
   a_ref_range: assert property (s_sel_write |=> {range_high_o, range_low_o, level_o}
      == $past(reg_wdata_i[5:0]))
      else $error("reference range or level wrong");
   a_timer2_source: assert property (timer2_cmp_clk_o == port_a_pin_zero_o)
      else $error("timer2 source differs from result output");
   a_sync_latency: assert property (s_raw_steady |-> res_now == cmp_raw_i)
      else $error("synchronised result lags too long");

endmodule

`default_nettype wire

//--- sim/acc_analog_model.sv
// Behavioural analog front end: input selection, reference ladder and comparison
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model #(
   parameter logic [7:0] BANDGAP_LVL = 8'h4C
) (
   input  wire logic       core_clk_i,
   input  wire logic       enable_i,
   input  wire logic [2:0] minus_sel_i,
   input  wire logic       plus_sel_i,
   input  wire logic       range_high_i,
   input  wire logic       range_low_i,
   input  wire logic [3:0] level_i,
   input  wire logic [7:0] port_a_pin_three_i,
   input  wire logic [7:0] port_a_pin_four_i,
   input  wire logic [7:0] port_b_pin_six_i,
   input  wire logic [7:0] port_b_pin_seven_i,
   output logic            cmp_raw_o
);
   logic [7:0] ladder;
   logic [7:0] plus_lvl;
   logic [7:0] minus_lvl;
   logic       idle_bit = 1'b0;
   // Ladder rises with the level code, range bits shift its span
   assign ladder = {range_high_i, ~range_low_i, level_i, 2'b10};
   assign plus_lvl = plus_sel_i ? port_a_pin_four_i : ladder;
   // Minus input multiplexer, reserved codes give a top-rail level
   always_comb begin
      case (minus_sel_i)
         3'h0: minus_lvl = port_a_pin_three_i;
         3'h1: minus_lvl = port_a_pin_four_i;
         3'h2: minus_lvl = BANDGAP_LVL;
         3'h3: minus_lvl = ladder;
         3'h4: minus_lvl = port_b_pin_six_i;
         3'h5: minus_lvl = port_b_pin_seven_i;
         default: minus_lvl = 8'hFF;
      endcase
   end
   // A switched-off comparator gives a wandering output
   always @(posedge core_clk_i) idle_bit <= ~idle_bit;
   assign cmp_raw_o = enable_i ? (plus_lvl > minus_lvl) : idle_bit;
endmodule
`default_nettype wire

//--- sim/acc_top_bench.sv
// Self-checking bench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"
module acc_top_bench;
   logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, t2 = 1'b0, rd_d = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
   logic [7:0] v_a3 = 8'h00, v_a4 = 8'h00, v_b6 = 8'h00, v_b7 = 8'h00;
   logic       en, psel, rh, rl, pin, oe, t2o, wake, irq, raw;
   logic [2:0] msel;
   logic [3:0] lvl;
   logic [7:0] exp_q[$];
   int         mismatches = 0, checked = 0, wake_cnt = 0, seed = 33006, w, i;
   acc_top dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cmp_raw_i(raw), .timer2_clock_i(t2),
      .cmp_enable_o(en), .minus_sel_o(msel), .plus_sel_o(psel), .range_high_o(rh), .range_low_o(rl),
      .level_o(lvl), .port_a_pin_zero_o(pin), .port_a_pin_zero_oe_o(oe), .timer2_cmp_clk_o(t2o),
      .wakeup_o(wake), .irq_o(irq));
   acc_analog_model model (.core_clk_i(clk), .enable_i(en), .minus_sel_i(msel), .plus_sel_i(psel),
      .range_high_i(rh), .range_low_i(rl), .level_i(lvl), .port_a_pin_three_i(v_a3),
      .port_a_pin_four_i(v_a4), .port_b_pin_six_i(v_b6), .port_b_pin_seven_i(v_b7), .cmp_raw_o(raw));
   initial forever #5 clk = ~clk;
   task automatic stop_test;
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data compare against the oldest queued note
   task automatic check_rd;
      check(rdata, exp_q.pop_front());
   endtask
   // One bus cycle with a one-cycle strobe; a read notes its expected data
   task automatic bus(input logic w_n, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= w_n;
      rd <= ~w_n;
      addr <= a;
      wdata <= d;
      if (!w_n) exp_q.push_back(d);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic idle;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Bounded wait for the pin level, then timer2 source must match it
   task automatic wait_pin(input logic e);
      for (int k = 0; k < 40 && pin !== e; k++) @(negedge clk);
      if (pin !== e) begin
         mismatches++;
         stop_test;
      end
      check({7'h0, t2o}, {7'h0, e});
   endtask
   task automatic pulse_t2;
      @(posedge clk);
      t2 <= 1'b1;
      repeat (2) @(posedge clk);
      t2 <= 1'b0;
   endtask
   // Monitors: read data one cycle after the strobe, wake-up pulse count
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) if (rd_d) check_rd;
   always @(posedge clk) if (wake === 1'b1) wake_cnt++;
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      check({en, psel, oe, pin, irq, wake, t2o, rh}, 8'h00);
      bus(0, `ACC_ADDR_CTRL, 8'h00);
      bus(0, `ACC_ADDR_SEL, 8'h00);
      bus(0, `ACC_ADDR_STAT, 8'h00);
      bus(0, `ACC_ADDR_MASK, 8'h00);
      bus(0, 8'h20, 8'h00);
      for (i = 0; i < 16; i++) begin
         v = 8'($random(seed));
         v[7] = 1'b0;
         v[3:0] = 4'(i);
         bus(1, `ACC_ADDR_CTRL, v);
         bus(0, `ACC_ADDR_CTRL, v & 8'hBF);
         @(negedge clk);
         check({3'h0, en, msel, psel}, {3'h0, v[7], v[3:0]});
      end
      for (i = 0; i < 8; i++) begin
         v = (i < 2) ? (i == 0 ? 8'hFF : 8'h00) : 8'($random(seed));
         bus(1, `ACC_ADDR_SEL, v);
         bus(0, `ACC_ADDR_SEL, 8'h00);
         @(negedge clk);
         check({oe, 1'b0, rh, rl, lvl}, v & 8'hBF);
      end
      v_a3 <= 8'h10;
      v_a4 <= 8'h80;
      bus(1, `ACC_ADDR_MASK, 8'h03);
      bus(1, `ACC_ADDR_SEL, 8'hC0);
      w = wake_cnt;
      bus(1, `ACC_ADDR_CTRL, 8'h81);
      idle;
      wait_pin(1'b1);
      repeat (3) @(negedge clk);
      check({7'h0, irq}, 8'h01);
      check({7'h0, wake_cnt > w}, 8'h01);
      bus(0, `ACC_ADDR_CTRL, 8'hC1);
      bus(1, `ACC_ADDR_CTRL, 8'h91);
      idle;
      wait_pin(1'b0);
      bus(1, `ACC_ADDR_STAT, 8'h03);
      bus(0, `ACC_ADDR_STAT, 8'h00);
      idle;
      @(negedge clk);
      check({7'h0, irq}, 8'h00);
      w = wake_cnt;
      v_a4 <= 8'h00;
      wait_pin(1'b1);
      repeat (3) @(negedge clk);
      check(8'(wake_cnt - w), 8'h01);
      bus(0, `ACC_ADDR_CTRL, 8'h91);
      bus(1, `ACC_ADDR_MASK, 8'h00);
      bus(1, `ACC_ADDR_SEL, 8'h80);
      bus(1, `ACC_ADDR_STAT, 8'h03);
      idle;
      w = wake_cnt;
      v_a4 <= 8'h80;
      wait_pin(1'b0);
      repeat (3) @(negedge clk);
      check({irq, 7'(wake_cnt - w)}, 8'h00);
      bus(0, `ACC_ADDR_STAT, 8'h01);
      bus(1, `ACC_ADDR_CTRL, 8'hB1);
      idle;
      pulse_t2;
      wait_pin(1'b0);
      v_a4 <= 8'h00;
      repeat (10) @(negedge clk);
      check({7'h0, pin}, 8'h00);
      pulse_t2;
      wait_pin(1'b1);
      stop_test;
   end
endmodule
`default_nettype wire
